/* core/cnmt_pkg.sv */
package cnmt_pkg;
   // ------------------------------------------------------------
   // identifier layout
   // ------------------------------------------------------------
   localparam int ID_W = 11;
   localparam int FC_W = 4;
   localparam int NODE_W = 7;
   localparam int FC_LSB = 7;
   localparam logic [10:0] ID_NMT = 11'h000;
   localparam logic [10:0] ID_SYNC = 11'h080;
   // ------------------------------------------------------------
   // function codes
   // ------------------------------------------------------------
   localparam logic [3:0] FC_EMCY = 4'h1;
   localparam logic [3:0] FC_TPDO1 = 4'h3;
   localparam logic [3:0] FC_RPDO1 = 4'h4;
   localparam logic [3:0] FC_TPDO2 = 4'h5;
   localparam logic [3:0] FC_RPDO2 = 4'h6;
   localparam logic [3:0] FC_TPDO3 = 4'h7;
   localparam logic [3:0] FC_RPDO3 = 4'h8;
   localparam logic [3:0] FC_TPDO4 = 4'h9;
   localparam logic [3:0] FC_RPDO4 = 4'ha;
   localparam logic [3:0] FC_SDO_TX = 4'hb;
   localparam logic [3:0] FC_SDO_RX = 4'hc;
   localparam logic [3:0] FC_ERRCTL = 4'he;
   // ------------------------------------------------------------
   // network management commands and frame sizes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_START = 8'h01;
   localparam logic [7:0] CMD_STOP = 8'h02;
   localparam logic [7:0] CMD_PREOP = 8'h80;
   localparam logic [7:0] CMD_RST_NODE = 8'h81;
   localparam logic [7:0] CMD_RST_COMM = 8'h82;
   localparam logic [6:0] NODE_BCAST = 7'h00;
   localparam logic [3:0] DLC_NMT = 4'h2;
   localparam logic [3:0] DLC_MAX = 4'h8;
   localparam logic [3:0] DLC_ERRCTL = 4'h1;
   localparam logic [7:0] BOOT_BYTE = 8'h00;
   // ------------------------------------------------------------
   // reported state codes
   // ------------------------------------------------------------
   localparam logic [6:0] CODE_INIT = 7'h00;
   localparam logic [6:0] CODE_STOP = 7'h04;
   localparam logic [6:0] CODE_OPER = 7'h05;
   localparam logic [6:0] CODE_PREOP = 7'h7f;
   // ------------------------------------------------------------
   // received frame kinds and application transmit selectors
   // ------------------------------------------------------------
   localparam logic [2:0] KIND_NONE = 3'h0;
   localparam logic [2:0] KIND_NMT = 3'h1;
   localparam logic [2:0] KIND_SYNC = 3'h2;
   localparam logic [2:0] KIND_RPDO = 3'h3;
   localparam logic [2:0] KIND_SDO = 3'h4;
   localparam logic [2:0] KIND_GUARD = 3'h5;
   localparam logic [2:0] SEL_EMCY = 3'h0;
   localparam logic [2:0] SEL_TPDO1 = 3'h1;
   localparam logic [2:0] SEL_TPDO2 = 3'h2;
   localparam logic [2:0] SEL_TPDO3 = 3'h3;
   localparam logic [2:0] SEL_TPDO4 = 3'h4;
   localparam logic [2:0] SEL_SDO = 3'h5;

   // gray order along init, pre-operational, operational, stopped
   typedef enum logic [1:0] {
      ST_INIT = 2'b00,
      ST_PREOP = 2'b01,
      ST_OPER = 2'b11,
      ST_STOP = 2'b10
   } cnmt_state_e;

   function automatic logic [10:0] cnmt_cob_id(input logic [3:0] fc, input logic [6:0] node);
      cnmt_cob_id = {fc, node};
   endfunction : cnmt_cob_id
endpackage : cnmt_pkg

/* core/cnmt_core.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - standard frames, 11-bit id, 0-8 bytes
// - id is function code over node address
// - accept NMT, SYNC, own RPDO, own SDO
// - send EMCY, TPDO, SDO reply, error control
// - data frames except remote guard request
// - power-up enters initialization by itself
// - initialization done moves to pre-operational
// - start command enters operational
// - pre-operational command enters pre-operational
// - stop command enters stopped
// - reset node restarts in initialization
// - reset communication restarts in initialization
// - services gated by current state
// - command byte codes 01,02,80,81,82
// - execute broadcast or own-address commands
// - seven-bit state codes 00,04,05,7f
// - one zero byte boot-up on leaving init
module cnmt_core import cnmt_pkg::*; (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic [6:0] node_addr_i,
   input wire logic init_done_i,
   input wire logic rx_valid_i,
   input wire logic [10:0] rx_id_i,
   input wire logic rx_rtr_i,
   input wire logic [3:0] rx_dlc_i,
   input wire logic [7:0] rx_byte0_i,
   input wire logic [7:0] rx_byte1_i,
   output logic rx_hit_o,
   output logic [2:0] rx_kind_o,
   input wire logic app_tx_valid_i,
   input wire logic [2:0] app_tx_sel_i,
   input wire logic [3:0] app_tx_dlc_i,
   input wire logic [63:0] app_tx_data_i,
   output logic app_tx_ready_o,
   output logic tx_valid_o,
   output logic [10:0] tx_id_o,
   output logic tx_rtr_o,
   output logic [3:0] tx_dlc_o,
   output logic [63:0] tx_data_o,
   input wire logic tx_ready_i,
   output logic [6:0] state_code_o,
   output logic pdo_en_o,
   output logic sdo_en_o,
   output logic sync_en_o,
   output logic emcy_en_o,
   output logic nmt_en_o,
   output logic errctl_en_o,
   output logic node_reset_o,
   output logic comm_reset_o
);
   // ------------------------------------------------------------
   // state and decode
   // ------------------------------------------------------------
   cnmt_state_e state, next_state;
   logic [6:0] node_id, rx_node;
   logic [3:0] rx_fc, app_fc;
   logic boot_pend, guard_pend, toggle, node_ok, own_frame, frame_ok, nmt_cmd, guard_req;
   logic sync_hit, rpdo_hit, sdo_hit, slot_free, load_boot, load_guard, load_app, app_allowed;
   assign node_ok = (node_id != NODE_BCAST);
   assign rx_fc = rx_id_i[10:FC_LSB];
   assign rx_node = rx_id_i[6:0];
   assign own_frame = node_ok && (rx_node == node_id);
   assign frame_ok = rx_valid_i && (rx_dlc_i <= DLC_MAX);
   assign nmt_cmd = frame_ok && !rx_rtr_i && (rx_id_i == ID_NMT) && (rx_dlc_i >= DLC_NMT)
                    && state != ST_INIT && ((rx_byte1_i[6:0] == NODE_BCAST && !rx_byte1_i[7])
                    || (node_ok && rx_byte1_i == {1'b0, node_id}));
   // guard request is the remote frame
   assign guard_req = frame_ok && rx_rtr_i && (rx_fc == FC_ERRCTL) && own_frame && errctl_en_o;
   assign sync_hit = frame_ok && !rx_rtr_i && (rx_id_i == ID_SYNC) && sync_en_o;
   assign rpdo_hit = frame_ok && !rx_rtr_i && own_frame && pdo_en_o
                     && (rx_fc == FC_RPDO1 || rx_fc == FC_RPDO2 || rx_fc == FC_RPDO3 || rx_fc == FC_RPDO4);
   assign sdo_hit = frame_ok && !rx_rtr_i && own_frame && sdo_en_o && (rx_fc == FC_SDO_RX);

   // ------------------------------------------------------------
   // network management state machine
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         ST_INIT: next_state = init_done_i ? ST_PREOP : ST_INIT;
         ST_PREOP, ST_OPER, ST_STOP: begin
            if (nmt_cmd) begin
               case (rx_byte0_i)
                  CMD_START: next_state = ST_OPER;
                  CMD_STOP: next_state = ST_STOP;
                  CMD_PREOP: next_state = ST_PREOP;
                  CMD_RST_NODE, CMD_RST_COMM: next_state = ST_INIT;
                  default: next_state = state;
               endcase
            end
         end
         default: next_state = ST_INIT;
      endcase
   end
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= ST_INIT;
      end else if (clk_en_i) begin
         state <= next_state;
      end
   end
   // address is static, reloaded each time init is passed
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         node_id <= NODE_BCAST;
      end else if (clk_en_i && state == ST_INIT) begin
         node_id <= node_addr_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         node_reset_o <= 1'b0;
         comm_reset_o <= 1'b0;
      end else if (clk_en_i) begin
         node_reset_o <= nmt_cmd && rx_byte0_i == CMD_RST_NODE;
         comm_reset_o <= nmt_cmd && rx_byte0_i == CMD_RST_COMM;
      end
   end

   // ------------------------------------------------------------
   // service gating and state report
   // ------------------------------------------------------------
   // state code mapping
   always_comb begin
      case (state)
         ST_PREOP: state_code_o = CODE_PREOP;
         ST_OPER: state_code_o = CODE_OPER;
         ST_STOP: state_code_o = CODE_STOP;
         default: state_code_o = CODE_INIT;
      endcase
   end

   assign pdo_en_o = (state == ST_OPER);
   assign sdo_en_o = (state == ST_PREOP) || (state == ST_OPER);
   assign sync_en_o = sdo_en_o;
   assign emcy_en_o = sdo_en_o;
   assign nmt_en_o = sdo_en_o;
   assign errctl_en_o = (state != ST_INIT);

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_hit_o <= 1'b0;
         rx_kind_o <= KIND_NONE;
      end else if (clk_en_i) begin
         rx_hit_o <= nmt_cmd || guard_req || sync_hit || rpdo_hit || sdo_hit;
         rx_kind_o <= nmt_cmd ? KIND_NMT : guard_req ? KIND_GUARD : sync_hit ? KIND_SYNC :
                      rpdo_hit ? KIND_RPDO : sdo_hit ? KIND_SDO : KIND_NONE;
      end
   end

   // ------------------------------------------------------------
   // transmit slot: boot-up, then guard reply, then application
   // ------------------------------------------------------------
   always_comb begin
      case (app_tx_sel_i)
         SEL_TPDO1: app_fc = FC_TPDO1;
         SEL_TPDO2: app_fc = FC_TPDO2;
         SEL_TPDO3: app_fc = FC_TPDO3;
         SEL_TPDO4: app_fc = FC_TPDO4;
         SEL_SDO: app_fc = FC_SDO_TX;
         default: app_fc = FC_EMCY;
      endcase
   end

   // transmit gating, refused frames are taken and dropped
   assign app_allowed = node_ok && (app_tx_sel_i == SEL_EMCY ? emcy_en_o :
                        app_tx_sel_i == SEL_SDO ? sdo_en_o :
                        app_tx_sel_i <= SEL_TPDO4 ? pdo_en_o : 1'b0);
   assign slot_free = !tx_valid_o || tx_ready_i;
   assign load_boot = slot_free && boot_pend && errctl_en_o;
   assign load_guard = slot_free && !boot_pend && guard_pend && errctl_en_o;
   assign app_tx_ready_o = slot_free && !boot_pend && !guard_pend && clk_en_i;
   assign load_app = app_tx_ready_o && app_tx_valid_i && app_allowed;
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         boot_pend <= 1'b0;
      end else if (clk_en_i) begin
         if (state == ST_INIT && next_state == ST_PREOP) begin
            boot_pend <= 1'b1;
         end else if (load_boot || state == ST_INIT) begin
            boot_pend <= 1'b0;
         end
      end
   end
   // a new guard request in the cycle its reply loads stays pending
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         guard_pend <= 1'b0;
      end else if (clk_en_i) begin
         if (guard_req) begin
            guard_pend <= 1'b1;
         end else if (load_guard || state == ST_INIT) begin
            guard_pend <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         toggle <= 1'b0;
      end else if (clk_en_i) begin
         if (state == ST_INIT) begin
            toggle <= 1'b0;
         end else if (load_guard) begin
            toggle <= !toggle;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_valid_o <= 1'b0;
         tx_id_o <= ID_NMT;
         tx_rtr_o <= 1'b0;
         tx_dlc_o <= 4'h0;
         tx_data_o <= 64'h0;
      end else if (clk_en_i && slot_free) begin
         tx_valid_o <= load_boot || load_guard || load_app;
         tx_rtr_o <= 1'b0;
         if (load_boot || load_guard) begin
            tx_id_o <= cnmt_cob_id(FC_ERRCTL, node_id);
            tx_dlc_o <= DLC_ERRCTL;
            tx_data_o <= {56'h0, load_boot ? BOOT_BYTE : {toggle, state_code_o}};
         end else if (load_app) begin
            tx_id_o <= cnmt_cob_id(app_fc, node_id);
            tx_dlc_o <= (app_tx_dlc_i > DLC_MAX) ? DLC_MAX : app_tx_dlc_i;
            tx_data_o <= app_tx_data_i;
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   chk_start_oper: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_en_i && nmt_cmd && rx_byte0_i == CMD_START |=> state == ST_OPER)
      else $error("start command did not reach operational");
   chk_stop_state: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_en_i && nmt_cmd && rx_byte0_i == CMD_STOP |=> state_code_o == CODE_STOP)
      else $error("stop command did not reach stopped");
   chk_preop_cmd: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_en_i && nmt_cmd && rx_byte0_i == CMD_PREOP |=> state_code_o == CODE_PREOP)
      else $error("pre-operational command ignored");
   chk_reset_init: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_en_i && nmt_cmd && rx_byte0_i == CMD_RST_NODE |=> node_reset_o && state == ST_INIT)
      else $error("node reset did not restart init");
   chk_comm_reset: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_en_i && nmt_cmd && rx_byte0_i == CMD_RST_COMM |=> comm_reset_o && !node_reset_o && state == ST_INIT)
      else $error("communication reset wrong");
   chk_init_leave: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_en_i && state == ST_INIT && init_done_i |=> state == ST_PREOP && boot_pend)
      else $error("init did not move to pre-operational");
   chk_boot_frame: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_en_i && load_boot |=> tx_valid_o && tx_id_o == {FC_ERRCTL, node_id} && tx_dlc_o == DLC_ERRCTL
      && tx_data_o[7:0] == BOOT_BYTE)
      else $error("boot-up frame malformed");
   chk_pdo_gate: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      rx_hit_o && rx_kind_o == KIND_RPDO |-> $past(state) == ST_OPER)
      else $error("receive PDO served outside operational");
   chk_guard_code: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_en_i && load_guard |=> tx_data_o[6:0] == $past(state_code_o) && tx_data_o[7] != toggle)
      else $error("guard reply state or toggle wrong");
   chk_foreign_drop: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_en_i && rx_valid_i && rx_id_i != ID_NMT && rx_id_i != ID_SYNC && rx_node != node_id |=> !rx_hit_o)
      else $error("foreign node frame accepted");
endmodule : cnmt_core

/* testbench/cnmt_master_model.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// master station: sends frames, takes node frames
// ------------------------------------------------------------
module cnmt_master_model (
   input wire logic ref_clk_i,
   input wire logic slow_i,
   input wire logic tx_valid_i,
   input wire logic [10:0] tx_id_i,
   input wire logic [3:0] tx_dlc_i,
   input wire logic [63:0] tx_data_i,
   output logic tx_ready_o,
   output logic rx_valid_o,
   output logic [10:0] rx_id_o,
   output logic rx_rtr_o,
   output logic [3:0] rx_dlc_o,
   output logic [7:0] rx_byte0_o,
   output logic [7:0] rx_byte1_o
);
   logic [10:0] got_id[$];
   logic [3:0] got_dlc[$];
   logic [7:0] got_b0[$];
   logic [3:0] tick = 4'h0;

   initial begin
      rx_valid_o = 1'b0;
      rx_id_o = 11'h7ff;
      rx_rtr_o = 1'b1;
      rx_dlc_o = 4'hf;
      rx_byte0_o = 8'hff;
      rx_byte1_o = 8'hff;
   end

   // 11-bit id, data unless remote, command bytes
   task automatic send(input logic [10:0] id, input logic rtr, input logic [3:0] dlc,
                       input logic [7:0] b0, input logic [7:0] b1);
      @(negedge ref_clk_i);
      rx_valid_o = 1'b1;
      rx_id_o = id;
      rx_rtr_o = rtr;
      rx_dlc_o = dlc;
      rx_byte0_o = b0;
      rx_byte1_o = b1;
      @(negedge ref_clk_i);
      // idle lines inverted so a stale frame never looks valid
      rx_valid_o = 1'b0;
      rx_id_o = ~id;
      rx_rtr_o = ~rtr;
      rx_dlc_o = ~dlc;
      rx_byte0_o = ~b0;
      rx_byte1_o = ~b1;
   endtask : send

   // busy bus: accepts one cycle in four when slow
   always @(negedge ref_clk_i) begin
      tick <= tick + 4'h1;
      tx_ready_o <= !slow_i || (tick[1:0] == 2'h3);
   end

   always @(posedge ref_clk_i) begin
      if (tx_valid_i === 1'b1 && tx_ready_o) begin
         got_id.push_back(tx_id_i);
         got_dlc.push_back(tx_dlc_i);
         got_b0.push_back(tx_data_i[7:0]);
      end
   end
endmodule : cnmt_master_model

/* testbench/tb_canopen_nmt_state_and_cobid_map.sv */
`timescale 1ns/100ps
module tb_canopen_nmt_state_and_cobid_map
   import cnmt_pkg::*;
;
   localparam logic [6:0] NODE = 7'h45;
   logic ref_clk_i = 1'b0, reset_n_i = 1'b0, clk_en_i = 1'b1, init_done_i = 1'b0, slow = 1'b0;
   logic [6:0] node_addr_i = NODE;
   logic rx_valid_i, rx_rtr_i, rx_hit_o, app_tx_valid_i = 1'b0, app_tx_ready_o;
   logic [10:0] rx_id_i, tx_id_o;
   logic [3:0] rx_dlc_i, tx_dlc_o, app_tx_dlc_i = 4'h0;
   logic [7:0] rx_byte0_i, rx_byte1_i;
   logic [2:0] rx_kind_o, app_tx_sel_i = 3'h0;
   logic [63:0] app_tx_data_i = 64'h0, tx_data_o;
   logic tx_valid_o, tx_rtr_o, tx_ready_i, pdo_en_o, sdo_en_o, sync_en_o, emcy_en_o, nmt_en_o, errctl_en_o;
   logic [6:0] state_code_o;
   logic node_reset_o, comm_reset_o;
   int err_total = 0, n_checks = 0, cyc = 0;

   always #20 ref_clk_i = ~ref_clk_i;

   cnmt_core dut (.ref_clk_i, .reset_n_i, .clk_en_i, .node_addr_i, .init_done_i, .rx_valid_i, .rx_id_i,
      .rx_rtr_i, .rx_dlc_i, .rx_byte0_i, .rx_byte1_i, .rx_hit_o, .rx_kind_o, .app_tx_valid_i, .app_tx_sel_i,
      .app_tx_dlc_i, .app_tx_data_i, .app_tx_ready_o, .tx_valid_o, .tx_id_o, .tx_rtr_o, .tx_dlc_o, .tx_data_o,
      .tx_ready_i, .state_code_o, .pdo_en_o, .sdo_en_o, .sync_en_o, .emcy_en_o, .nmt_en_o, .errctl_en_o,
      .node_reset_o, .comm_reset_o);

   cnmt_master_model mm (.ref_clk_i, .slow_i(slow), .tx_valid_i(tx_valid_o), .tx_id_i(tx_id_o),
      .tx_dlc_i(tx_dlc_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i),
      .rx_id_o(rx_id_i), .rx_rtr_o(rx_rtr_i), .rx_dlc_o(rx_dlc_i), .rx_byte0_o(rx_byte0_i),
      .rx_byte1_o(rx_byte1_i));

   // ------------------------------------------------------------
   // shared helpers
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] seen);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize

   task automatic chk_state(input logic [6:0] code);
      chk("state", code, state_code_o);
      chk("pdo_en", code == CODE_OPER, pdo_en_o);
      chk("svc_en", {3{code == CODE_OPER || code == CODE_PREOP}}, {sync_en_o, emcy_en_o, nmt_en_o});
      chk("sdo_en", code == CODE_OPER || code == CODE_PREOP, sdo_en_o);
      chk("errctl_en", code != CODE_INIT, errctl_en_o);
   endtask : chk_state

   task automatic rx(input logic [10:0] id, input logic rtr, input logic [7:0] b0, input logic [7:0] b1,
                     input logic [2:0] kind);
      mm.send(id, rtr, rtr ? 4'h0 : DLC_NMT, b0, b1);
      chk("rx_hit", kind != KIND_NONE, rx_hit_o);
      if (kind != KIND_NONE) chk("rx_kind", kind, rx_kind_o);
   endtask : rx

   task automatic wait_tx(input logic [10:0] id, input logic [3:0] dlc, input logic [7:0] b0);
      for (int k = 0; k < 40 && mm.got_id.size() == 0; k++) @(negedge ref_clk_i);
      chk("tx_seen", 1, mm.got_id.size() != 0);
      if (mm.got_id.size() != 0) begin
         chk("tx_id", id, mm.got_id.pop_front());
         chk("tx_dlc", dlc, mm.got_dlc.pop_front());
         chk("tx_byte0", b0, mm.got_b0.pop_front());
         chk("tx_rtr", 0, tx_rtr_o);
      end
   endtask : wait_tx

   // valid left high so frames can follow back to back
   task automatic app_send(input logic [2:0] sel, input logic [3:0] dlc, input logic [7:0] b0);
      @(negedge ref_clk_i);
      app_tx_valid_i = 1'b1;
      app_tx_sel_i = sel;
      app_tx_dlc_i = dlc;
      app_tx_data_i = {56'h0, b0};
      #1;
      for (int k = 0; k < 40 && app_tx_ready_o !== 1'b1; k++) begin
         @(negedge ref_clk_i);
         #1;
      end
      @(posedge ref_clk_i);
   endtask : app_send

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_boot();
      chk_state(CODE_INIT);
      chk("app_ready", 1, app_tx_ready_o);
      slow = 1'b1;
      @(negedge ref_clk_i);
      init_done_i = 1'b1;
      @(negedge ref_clk_i);
      chk_state(CODE_PREOP);
      wait_tx({FC_ERRCTL, NODE}, DLC_ERRCTL, BOOT_BYTE);
      slow = 1'b0;
   endtask : t_boot

   task automatic t_nmt();
      logic [7:0] cmd[6] = '{CMD_START, CMD_STOP, CMD_PREOP, CMD_STOP, CMD_START, CMD_PREOP};
      logic [6:0] code[6] = '{CODE_OPER, CODE_STOP, CODE_PREOP, CODE_STOP, CODE_OPER, CODE_PREOP};
      for (int i = 0; i < 6; i++) begin
         rx(ID_NMT, 1'b0, cmd[i], i[0] ? {1'b0, NODE} : 8'h00, KIND_NMT);
         chk_state(code[i]);
      end
      rx(ID_NMT, 1'b0, CMD_START, {1'b0, NODE + 7'h1}, KIND_NONE);
      rx(ID_NMT, 1'b0, 8'h55, 8'h00, KIND_NMT);
      chk_state(CODE_PREOP);
      clk_en_i = 1'b0;
      mm.send(ID_NMT, 1'b0, DLC_NMT, CMD_START, 8'h00);
      clk_en_i = 1'b1;
      chk_state(CODE_PREOP);
   endtask : t_nmt

   task automatic t_rx();
      logic [3:0] fc[4] = '{FC_RPDO1, FC_RPDO2, FC_RPDO3, FC_RPDO4};
      rx(ID_SYNC, 1'b0, 8'h00, 8'h00, KIND_SYNC);
      rx({FC_SDO_RX, NODE}, 1'b0, 8'h40, 8'h00, KIND_SDO);
      rx({FC_RPDO1, NODE}, 1'b0, 8'h11, 8'h22, KIND_NONE);
      rx(ID_NMT, 1'b0, CMD_START, 8'h00, KIND_NMT);
      foreach (fc[i]) rx({fc[i], NODE}, 1'b0, 8'h11, 8'h22, KIND_RPDO);
      rx({FC_SDO_RX, NODE ^ 7'h01}, 1'b0, 8'h40, 8'h00, KIND_NONE);
      rx({FC_SDO_RX, NODE}, 1'b1, 8'h40, 8'h00, KIND_NONE);
   endtask : t_rx

   task automatic t_tx();
      logic [3:0] fc[6] = '{FC_EMCY, FC_TPDO1, FC_TPDO2, FC_TPDO3, FC_TPDO4, FC_SDO_TX};
      slow = 1'b1;
      for (int i = 0; i < 6; i++) app_send(i[2:0], (i == 5) ? 4'h9 : i[3:0] + 4'h1, 8'ha0 + i[7:0]);
      @(negedge ref_clk_i);
      app_tx_valid_i = 1'b0;
      for (int i = 0; i < 6; i++) wait_tx({fc[i], NODE}, (i == 5) ? DLC_MAX : i[3:0] + 4'h1, 8'ha0 + i[7:0]);
      slow = 1'b0;
      rx(ID_NMT, 1'b0, CMD_STOP, {1'b0, NODE}, KIND_NMT);
      app_send(SEL_TPDO1, 4'h1, 8'h5a);
      app_send(SEL_EMCY, 4'h1, 8'h5b);
      @(negedge ref_clk_i);
      app_tx_valid_i = 1'b0;
      repeat (10) @(negedge ref_clk_i);
      chk("tx_dropped", 0, mm.got_id.size());
   endtask : t_tx

   task automatic t_guard(input logic [6:0] code, input logic tog);
      rx({FC_ERRCTL, NODE}, 1'b1, 8'h00, 8'h00, KIND_GUARD);
      wait_tx({FC_ERRCTL, NODE}, DLC_ERRCTL, {tog, code});
   endtask : t_guard

   task automatic t_reset();
      rx(ID_NMT, 1'b0, CMD_RST_COMM, {1'b0, NODE}, KIND_NMT);
      chk("comm_reset", 1, comm_reset_o);
      chk("node_reset", 0, node_reset_o);
      chk_state(CODE_INIT);
      @(negedge ref_clk_i);
      chk_state(CODE_PREOP);
      wait_tx({FC_ERRCTL, NODE}, DLC_ERRCTL, BOOT_BYTE);
      t_guard(CODE_PREOP, 1'b0);
      rx(ID_NMT, 1'b0, CMD_START, 8'h00, KIND_NMT);
      rx(ID_NMT, 1'b0, CMD_RST_NODE, 8'h00, KIND_NMT);
      chk("node_reset", 1, node_reset_o);
      chk("comm_reset", 0, comm_reset_o);
      chk_state(CODE_INIT);
      wait_tx({FC_ERRCTL, NODE}, DLC_ERRCTL, BOOT_BYTE);
   endtask : t_reset

   initial begin
      repeat (10) @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      t_boot();
      t_nmt();
      t_rx();
      t_tx();
      t_guard(CODE_STOP, 1'b0);
      t_guard(CODE_STOP, 1'b1);
      t_reset();
      summarize();
   end

   // hang guard: the whole run needs well under two thousand cycles
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         summarize();
      end
   end
endmodule : tb_canopen_nmt_state_and_cobid_map
